// ---- src/pfsc_ctrl.sv ----
// frequency switch, pin function and output gating control
`timescale 1ns/10ps
`default_nettype none
module pfsc_ctrl #(
    parameter int     DW        = pfsc_pkg::DIV_W,
    parameter longint BASE_CYC  = pfsc_pkg::TMO_BASE_CYC,
    parameter longint PULSE_CYC = pfsc_pkg::RST_PULSE_CYC
) (
    // clock, reset, enable
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // staged register writes from the bus engine
    input  wire logic          wr_valid,
    input  wire logic          wr_stop,
    input  wire logic          wr_divider,
    input  wire logic [DW-1:0] wr_divider_data,
    input  wire logic          wr_ctrl,
    input  wire logic [1:0]    wr_pin1_function_select,
    input  wire logic [1:0]    wr_pin3_function_select,
    input  wire logic          wr_freq_switch_enable,
    input  wire logic [1:0]    wr_reg_freq_select,
    input  wire logic [1:0]    wr_config_select,
    input  wire logic          wr_bus_pin_switch_flag,
    input  wire logic          wr_timer_enable,
    input  wire logic [1:0]    wr_timer_interval,
    input  wire logic          wr_reset_out_enable,
    input  wire logic          wr_bus_oe_enable,
    input  wire logic [2:0]    wr_out_enable,
    input  wire logic [7:0]    wr_xtal_tune,
    // pins
    input  wire logic          multi_function_pin_1,
    input  wire logic          multi_function_pin_3,
    input  wire logic          bus_clock_pin,
    input  wire logic          bus_data_select_bit0,
    // pin 1 driven as reset output
    output logic               pin1_out,
    output logic               pin1_oe,
    // vco and output control
    output logic [DW-1:0]      vco_divider,
    output logic               overshoot_limit_ramp,
    output logic [1:0]         freq_select_code,
    output logic               single_ended_out_1_run,
    output logic               single_ended_out_1_low_power,
    output logic               single_ended_out_2_run,
    output logic               single_ended_out_3_run,
    output logic               differential_out_1_run,
    output logic               differential_out_2_run,
    output logic               clk32k_run,
    output logic               xtal_calibration_run,
    output logic [7:0]         xtal_tune_code,
    // status
    output logic               timeout_flag,
    output logic               power_down_active
);
    // committed control state
    logic [DW-1:0] div_slot_reg [4];
    logic [1:0]    pin1_fun_reg;
    logic [1:0]    pin3_fun_reg;
    logic          sw_en_reg;
    logic [1:0]    reg_sel_reg;
    logic [1:0]    cfg_sel_reg;
    logic          bus_flag_reg;
    logic          tmr_en_reg;
    logic [1:0]    tmr_int_reg;
    logic          rst_out_en_reg;
    logic          bus_oe_reg;
    logic [2:0]    out_en_reg;
    logic [7:0]    xtal_reg;
    logic          sel_force_zero_reg;
    logic          switch_kill_reg;
    logic          reset_seen_reg;
    logic [1:0]    sel_next;
    logic          expire;
    logic          reset_pulse;
    logic          commit;

    // staged bytes take effect only on the stop condition
    assign commit = ce && wr_valid && wr_stop;

    // stored divider slots, one per configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) div_slot_reg[i] <= pfsc_pkg::DIV_RESET_VALUE;
        end else if (commit && wr_divider) begin
            div_slot_reg[wr_config_select] <= wr_divider_data;
        end
    end

    // control register commit; pin functions reset to output enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_fun_reg   <= pfsc_pkg::FUN_RESET_VALUE;
            pin3_fun_reg   <= pfsc_pkg::FUN_RESET_VALUE;
            sw_en_reg      <= 1'b0;
            reg_sel_reg    <= pfsc_pkg::CFG_ZERO;
            cfg_sel_reg    <= pfsc_pkg::CFG_ZERO;
            bus_flag_reg   <= 1'b0;
            tmr_en_reg     <= 1'b0;
            tmr_int_reg    <= 2'h0;
            rst_out_en_reg <= 1'b0;
            bus_oe_reg     <= 1'b1;
            out_en_reg     <= 3'h7;
            xtal_reg       <= 8'h00;
        end else if (commit && wr_ctrl) begin
            pin1_fun_reg   <= wr_pin1_function_select;
            pin3_fun_reg   <= wr_pin3_function_select;
            sw_en_reg      <= wr_freq_switch_enable;
            reg_sel_reg    <= wr_reg_freq_select;
            cfg_sel_reg    <= wr_config_select;
            bus_flag_reg   <= wr_bus_pin_switch_flag;
            tmr_en_reg     <= wr_timer_enable;
            tmr_int_reg    <= wr_timer_interval;
            rst_out_en_reg <= wr_reset_out_enable;
            bus_oe_reg     <= wr_bus_oe_enable;
            out_en_reg     <= wr_out_enable;
            xtal_reg       <= wr_xtal_tune;
        end
    end

    // expiry forces config zero; the reset pulse ending disables switching.
    // a control register write after the pulse ends re-arms both.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_force_zero_reg <= 1'b0;
            reset_seen_reg     <= 1'b0;
            switch_kill_reg    <= 1'b0;
        end else if (ce) begin
            if (expire && sw_en_reg) begin
                sel_force_zero_reg <= 1'b1;
                reset_seen_reg     <= 1'b1;
            end else if (commit && wr_ctrl) begin
                sel_force_zero_reg <= 1'b0;
                switch_kill_reg    <= 1'b0;
            end else if (reset_seen_reg && !reset_pulse) begin
                reset_seen_reg  <= 1'b0;
                switch_kill_reg <= 1'b1;
            end
        end
    end

    // select source priority
    always_comb begin
        sel_next = 2'h0;
        if (!sw_en_reg || switch_kill_reg || sel_force_zero_reg) begin
            sel_next = pfsc_pkg::CFG_ZERO;
        end else if (pin1_fun_reg == pfsc_pkg::FUN_SWITCH) begin
            if (pin3_fun_reg == pfsc_pkg::FUN_SWITCH)
                sel_next = {multi_function_pin_3, multi_function_pin_1};
            else
                sel_next = {1'b0, multi_function_pin_1};
        end else if (pin3_fun_reg == pfsc_pkg::FUN_SWITCH) begin
            sel_next = pfsc_pkg::CFG_ZERO; // unsupported by host contract
        end else if (!bus_flag_reg) begin
            sel_next = {bus_clock_pin, bus_data_select_bit0};
        end else begin
            sel_next = reg_sel_reg;
        end
    end

    // registered select; data output from a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) freq_select_code <= pfsc_pkg::CFG_ZERO;
        else if (ce) freq_select_code <= sel_next;
    end

    // ramp from present divider to target slot
    pfsc_ramp #(.W(DW)) u_ramp (
        .clk     (clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .target  (div_slot_reg[freq_select_code]),
        .current (vco_divider),
        .ramping (overshoot_limit_ramp)
    );

    // watchdog timer
    pfsc_timer #(.BASE_CYC(BASE_CYC), .PULSE_CYC(PULSE_CYC)) u_timer (
        .clk              (clk),
        .rst_n            (rst_n),
        .ce               (ce),
        .timer_enable     (tmr_en_reg),
        .interval_sel     (tmr_int_reg),
        .reset_out_enable (rst_out_en_reg),
        .timeout_flag     (timeout_flag),
        .expire_pulse     (expire),
        .reset_pulse      (reset_pulse)
    );

    // pin 1 doubles as reset output, active low, while reset control is set
    assign pin1_oe  = rst_out_en_reg;
    assign pin1_out = !reset_pulse;

    // output gating: power-down dominates, then bus enable, then own enable
    logic pd_low;
    logic outs_ok;
    logic saver_down;
    assign pd_low     = (pin1_fun_reg == pfsc_pkg::FUN_PD) && !multi_function_pin_1;
    assign outs_ok    = !pd_low && bus_oe_reg;
    assign saver_down = (pin1_fun_reg == pfsc_pkg::FUN_SAVER) && !multi_function_pin_1;

    // outputs are registered so every run line is clean from reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_ended_out_1_run       <= 1'b0;
            single_ended_out_1_low_power <= 1'b0;
            single_ended_out_2_run       <= 1'b0;
            single_ended_out_3_run       <= 1'b0;
            differential_out_1_run       <= 1'b0;
            differential_out_2_run       <= 1'b0;
            power_down_active            <= 1'b0;
        end else if (ce) begin
            // only output 1 sees the pin in output-enable mode
            single_ended_out_1_run <= outs_ok && out_en_reg[0] && !saver_down
                && !((pin1_fun_reg == pfsc_pkg::FUN_OE) && !multi_function_pin_1);
            single_ended_out_1_low_power <= saver_down && !pd_low;
            single_ended_out_2_run <= outs_ok && out_en_reg[1];
            single_ended_out_3_run <= outs_ok && out_en_reg[2];
            differential_out_1_run <= outs_ok && out_en_reg[1];
            differential_out_2_run <= outs_ok && out_en_reg[2];
            power_down_active      <= pd_low;
        end
    end

    // the 32 khz clock and calibration free-run through power-down
    assign clk32k_run           = 1'b1;
    assign xtal_calibration_run = 1'b1;
    assign xtal_tune_code       = xtal_reg;

    a_pd_stops: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && pd_low) |=> !single_ended_out_2_run && !differential_out_1_run)
        else $error("output runs during power down");
    a_oe_gates: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && pin1_fun_reg == pfsc_pkg::FUN_OE && !multi_function_pin_1)
        |=> !single_ended_out_1_run)
        else $error("output enable pin did not gate output 1");
    a_sel_off: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !sw_en_reg) |=> freq_select_code == 2'h0)
        else $error("select not zero with switching off");
    a_sel_bus: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && sw_en_reg && !switch_kill_reg && !sel_force_zero_reg
         && pin1_fun_reg != 2'h3 && pin3_fun_reg != 2'h3 && !bus_flag_reg)
        |=> freq_select_code == $past({bus_clock_pin, bus_data_select_bit0}))
        else $error("bus pin select not taken");
    a_sel_reg: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && sw_en_reg && !switch_kill_reg && !sel_force_zero_reg
         && pin1_fun_reg != 2'h3 && pin3_fun_reg != 2'h3 && bus_flag_reg)
        |=> freq_select_code == $past(reg_sel_reg))
        else $error("register select not taken");
    a_expire_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (expire && sw_en_reg) |=> ##1 freq_select_code == 2'h0)
        else $error("expiry did not return to config zero");
    a_slot_write: assert property (@(posedge clk) disable iff (!rst_n)
        (commit && wr_divider) |=> div_slot_reg[$past(wr_config_select)]
        == $past(wr_divider_data))
        else $error("divider slot not written");
    a_saver_swap: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && saver_down && !pd_low) |=> single_ended_out_1_low_power
        && !single_ended_out_1_run)
        else $error("saver did not swap to low power clock");
    // bus enable off must stop all five run outputs, whatever the pin does
    a_bus_oe_off: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !bus_oe_reg) |=> !single_ended_out_1_run && !single_ended_out_2_run
        && !single_ended_out_3_run && !differential_out_1_run && !differential_out_2_run)
        else $error("output runs with bus enable off");
    // a staged write without its stop must leave the crystal tune register alone
    a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_valid && !wr_stop) |=> $stable(xtal_reg))
        else $error("staged write landed without stop");
endmodule
`default_nettype wire

// ---- src/pfsc_pkg.sv ----
// package of constants and types for the clock control block
package pfsc_pkg;
    // pin function select codes
    localparam logic [1:0] FUN_OE     = 2'h0;
    localparam logic [1:0] FUN_PD     = 2'h1;
    localparam logic [1:0] FUN_SAVER  = 2'h2;
    localparam logic [1:0] FUN_SWITCH = 2'h3;
    // reset-output role is selected by a separate control bit
    localparam logic [1:0] FUN_RESET_VALUE  = FUN_OE;
    localparam logic [1:0] CFG_ZERO         = 2'h0;
    // clock rate and timing
    localparam longint CLK_HZ          = 40000000;
    localparam longint TMO_BASE_MS     = 500;
    localparam longint RST_PULSE_MS    = 250;
    localparam longint TMO_BASE_CYC    = (CLK_HZ * TMO_BASE_MS) / 1000;
    localparam longint RST_PULSE_CYC   = (CLK_HZ * RST_PULSE_MS) / 1000;
    localparam int     DIV_W           = 32;
    localparam int     RAMP_STEP       = 1;
    localparam logic [DIV_W-1:0] DIV_RESET_VALUE = 32'h0000_0000;
    // ramp states
    typedef enum logic [2:0] {
        PFSC_IDLE = 3'b001,
        PFSC_UP   = 3'b010,
        PFSC_DOWN = 3'b100
    } pfsc_ramp_e;
endpackage

// ---- src/pfsc_ramp.sv ----
// overshoot-limiting ramp of the feedback divider toward a target
`timescale 1ns/10ps
`default_nettype none
module pfsc_ramp #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // target and output
    input  wire logic [W-1:0] target,
    output logic      [W-1:0] current,
    output logic              ramping
);
    pfsc_pkg::pfsc_ramp_e state_reg;
    logic [W-1:0] cur_reg;

    // step one code per cycle so the vco never jumps past the target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pfsc_pkg::PFSC_IDLE;
            cur_reg   <= pfsc_pkg::DIV_RESET_VALUE;
        end else if (ce) begin
            case (state_reg)
                pfsc_pkg::PFSC_IDLE: begin
                    if (target > cur_reg) state_reg <= pfsc_pkg::PFSC_UP;
                    else if (target < cur_reg) state_reg <= pfsc_pkg::PFSC_DOWN;
                end
                pfsc_pkg::PFSC_UP: begin
                    if (target > cur_reg) cur_reg <= cur_reg + W'(pfsc_pkg::RAMP_STEP);
                    else state_reg <= pfsc_pkg::PFSC_IDLE;
                end
                pfsc_pkg::PFSC_DOWN: begin
                    if (target < cur_reg) cur_reg <= cur_reg - W'(pfsc_pkg::RAMP_STEP);
                    else state_reg <= pfsc_pkg::PFSC_IDLE;
                end
                default: state_reg <= pfsc_pkg::PFSC_IDLE;
            endcase
        end
    end

    assign current = cur_reg;
    assign ramping = (state_reg != pfsc_pkg::PFSC_IDLE);
endmodule
`default_nettype wire

// ---- src/pfsc_timer.sv ----
// watchdog timer with timeout flag and reset-out pulse
`timescale 1ns/10ps
`default_nettype none
module pfsc_timer #(
    parameter longint BASE_CYC  = pfsc_pkg::TMO_BASE_CYC,
    parameter longint PULSE_CYC = pfsc_pkg::RST_PULSE_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // control
    input  wire logic       timer_enable,
    input  wire logic [1:0] interval_sel,
    input  wire logic       reset_out_enable,
    // status
    output logic            timeout_flag,
    output logic            expire_pulse,
    output logic            reset_pulse
);
    logic [31:0] cnt_reg;
    logic [31:0] pulse_reg;
    logic        flag_reg;
    logic [31:0] limit;
    logic        expire;

    // interval is 0.5 s shifted left by the select: 0.5, 1, 2, 4 s
    assign limit  = 32'(BASE_CYC) << interval_sel;
    assign expire = ce && timer_enable && !flag_reg && (cnt_reg == limit - 32'h1);

    // count while enabled and the flag is clear, restart when disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_reg <= 32'h0;
        else if (ce) begin
            if (!timer_enable || flag_reg) cnt_reg <= 32'h0;
            else cnt_reg <= cnt_reg + 32'h1;
        end
    end

    // set on expiry, clear by writing enable to 0; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) flag_reg <= 1'b0;
        else if (expire) flag_reg <= 1'b1;
        else if (ce && !timer_enable) flag_reg <= 1'b0;
    end

    // reset-out pulse of fixed length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pulse_reg <= 32'h0;
        else if (ce) begin
            if (expire && reset_out_enable) pulse_reg <= 32'(PULSE_CYC);
            else if (pulse_reg != 32'h0) pulse_reg <= pulse_reg - 32'h1;
        end
    end

    assign timeout_flag = flag_reg;
    assign expire_pulse = expire;
    assign reset_pulse  = (pulse_reg != 32'h0);

    a_pulse_length: assert property (@(posedge clk) disable iff (!rst_n)
        (expire && reset_out_enable) |=> (pulse_reg == 32'(PULSE_CYC)))
        else $error("reset pulse length not loaded");
    a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        expire |=> timeout_flag)
        else $error("timeout flag not set on expiry");
endmodule
`default_nettype wire

// ---- dv/pfsc_end_device.sv ----
// end device model that shows its power state on the saver monitor pin
`timescale 1ns/10ps
`default_nettype none
module pfsc_end_device (
    // clock and sleep command from the bench
    input  wire logic clk,
    input  wire logic asleep,
    // monitor pin towards the clock chip
    output logic      mon
);
    // pin low while asleep; registered so it only moves after a clock edge
    always_ff @(posedge clk) begin
        mon <= !asleep;
    end
endmodule
`default_nettype wire

// ---- dv/test_pfsc_ctrl.sv ----
// self-checking bench of the clock control block
`timescale 1ns/10ps
`default_nettype none
module test_pfsc_ctrl;
    // bench drive and design outputs
    logic        clk, rst_n, ce, wv, ws, wd, wc, sen, flg, ten, roe, boe, p1, p3, bc, bd;
    logic        slp, g, seen, po, poe, rmp, se1, lp, se2, se3, d1, d2, c32, xc, tf, pda;
    logic [1:0]  f1, f3, rs, cs, ti, fs;
    logic [2:0]  oen;
    logic [7:0]  xt, xo, xtc;
    logic [31:0] dd, vco, prev, st;
    logic [31:0] slot [4];
    wire  logic  dev;
    int          fail_count, checked, cyc, n, k, lim;
    // pin 1 comes from the end device only in saver mode
    wire  logic  pin1 = (f1 == pfsc_pkg::FUN_SAVER) ? dev : p1;

    pfsc_ctrl #(.BASE_CYC(20), .PULSE_CYC(10)) i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .wr_valid(wv), .wr_stop(ws), .wr_divider(wd),
        .wr_divider_data(dd), .wr_ctrl(wc), .wr_pin1_function_select(f1),
        .wr_pin3_function_select(f3), .wr_freq_switch_enable(sen), .wr_reg_freq_select(rs),
        .wr_config_select(cs), .wr_bus_pin_switch_flag(flg), .wr_timer_enable(ten),
        .wr_timer_interval(ti), .wr_reset_out_enable(roe), .wr_bus_oe_enable(boe),
        .wr_out_enable(oen), .wr_xtal_tune(xt), .multi_function_pin_1(pin1),
        .multi_function_pin_3(p3), .bus_clock_pin(bc), .bus_data_select_bit0(bd),
        .pin1_out(po), .pin1_oe(poe), .vco_divider(vco), .overshoot_limit_ramp(rmp),
        .freq_select_code(fs), .single_ended_out_1_run(se1),
        .single_ended_out_1_low_power(lp), .single_ended_out_2_run(se2),
        .single_ended_out_3_run(se3), .differential_out_1_run(d1),
        .differential_out_2_run(d2), .clk32k_run(c32), .xtal_calibration_run(xc),
        .xtal_tune_code(xtc), .timeout_flag(tf), .power_down_active(pda));

    pfsc_end_device i_dev (.clk(clk), .asleep(slp), .mon(dev));

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        checked++;
        if (v !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, v);
        end
    endtask

    task automatic tick(input int m);
        repeat (m) @(negedge clk);
    endtask

    // one staged write closed by a stop; commits on the edge between
    task automatic put(input logic d, input logic c);
        @(negedge clk);
        wv = 1'b1;
        ws = 1'b1;
        wd = d;
        wc = c;
        @(negedge clk);
        {wv, ws, wd, wc} = 4'h0;
    endtask

    task automatic results;
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // expected select source by priority of enable, pin roles and bus flag
    function automatic logic [1:0] esel(logic e, logic [1:0] a, logic [1:0] b, logic fl,
                                        logic [1:0] r, logic q1, logic q3, logic c, logic d);
        if (!e) return 2'h0;
        if (a == pfsc_pkg::FUN_SWITCH) return (b == pfsc_pkg::FUN_SWITCH) ? {q3, q1} : {1'b0, q1};
        if (b == pfsc_pkg::FUN_SWITCH) return 2'h0;
        return fl ? r : {c, d};
    endfunction

    initial begin
        {rst_n, wv, ws, wd, wc, sen, flg, ten, roe, p1, p3, bc, bd, slp} = '0;
        {f1, f3, rs, cs, ti, xt, dd} = '0;
        {ce, boe, oen} = 5'h1f;
        void'($urandom(8));
        tick(12);
        chk("reset_sel", 32'h0, 32'(fs));
        chk("reset_pin1", 32'h2, 32'({po, poe}));
        rst_n = 1'b1;
        // default pin role gates only the first output
        p1 = 1'b1;
        tick(2);
        chk("se1_default", 32'h1, 32'(se1)); // output enable role
        p1 = 1'b0;
        tick(2);
        chk("se1_off", 32'h0, 32'(se1)); // output enable role
        chk("se2_on", 32'h1, 32'(se2)); // other outputs ignore pin
        // select source priority, unsupported pin 3 case included
        for (n = 0; n < 48; n++) begin
            {sen, flg, f1, f3, rs} = 8'($urandom);
            put(1'b0, 1'b1);
            {p1, p3, bc, bd} = 4'($urandom);
            tick(2);
            chk("freq_select", 32'(esel(sen, f1, f3, flg, rs, pin1, p3, bc, bd)), 32'(fs));
        end
        // fill the four slots, last one small so a downward ramp happens
        {sen, flg, f1, f3} = 6'h30;
        for (k = 0; k < 4; k++) begin
            cs = 2'(k);
            dd = (k == 3) ? 32'h2 : 32'($urandom_range(60, 4));
            slot[k] = dd;
            put(1'b1, 1'b0); // slot chosen by config select
        end
        for (k = 1; k < 5; k++) begin
            rs = 2'(k % 4);
            st = vco;
            put(1'b0, 1'b1);
            prev = vco;
            seen = 1'b0;
            for (n = 0; n < 200 && !(vco === slot[k % 4] && rmp === 1'b0); n++) begin
                @(negedge clk);
                seen = seen | rmp;
                chk("ramp_step", 32'h1, 32'((vco - prev + 32'h1) <= 32'h2)); // smooth steps
                prev = vco;
            end
            chk("vco_divider", slot[k % 4], vco); // stored setting reached
            if (st !== slot[k % 4]) chk("ramp_flag", 32'h1, 32'(seen)); // ramp by itself
        end
        // output gating in enable and power-down roles, crystal code
        for (n = 0; n < 24; n++) begin
            f1 = 2'($urandom_range(1, 0));
            {boe, oen, p1} = 5'($urandom);
            xt = 8'($urandom_range(25, 14) - 14); // twice the load minus 7 pf, half pf units
            put(1'b0, 1'b1);
            tick(2);
            g = (f1 == pfsc_pkg::FUN_PD) ? p1 : 1'b1;
            chk("se1_run", 32'(p1 & boe & oen[0]), 32'(se1));
            chk("se2_run", 32'(g & boe & oen[1]), 32'(se2));
            chk("differential_out_1_run", 32'(g & boe & oen[1]), 32'(d1));
            chk("se3_run", 32'(g & boe & oen[2]), 32'(se3));
            chk("differential_out_2_run", 32'(g & boe & oen[2]), 32'(d2));
            chk("power_down", 32'(!g), 32'(pda)); // lowest power state
            chk("keep_32k", 32'h3, 32'({c32, xc})); // 32k and calibration run
            chk("xtal_code", 32'(xt), 32'(xtc));
        end
        // staged bytes without a stop never land
        xo = xt;
        xt = 8'h5a;
        @(negedge clk);
        {wv, wc} = 2'h3;
        @(negedge clk);
        {wv, wc} = 2'h0;
        tick(2);
        chk("no_stop", 32'(xo), 32'(xtc)); // commit only at stop
        // clock enable low freezes state, so even a stopped write is lost
        ce = 1'b0;
        put(1'b0, 1'b1);
        ce = 1'b1;
        tick(2);
        chk("ce_freeze", 32'(xo), 32'(xtc)); // no commit while frozen
        // saver monitor swaps the first output to the slow clock
        f1 = pfsc_pkg::FUN_SAVER; // code 10 selects the saver monitor
        put(1'b0, 1'b1);
        for (n = 0; n < 4; n++) begin
            slp = n[0];
            tick(3);
            chk("low_power", 32'(slp), 32'(lp));
        end
        // timer intervals, flag, reset pulse and fall back to config zero
        // switching on with register select 3, so the fall back is visible
        {f1, sen, flg, rs, roe} = 7'h1f;
        for (n = 0; n < 4; n++) begin
            ten = 1'b0;
            put(1'b0, 1'b1);
            tick(1); // the flag sees the committed enable one edge later
            chk("flag_clear", 32'h0, 32'(tf)); // cleared by enable 0
            ten = 1'b1;
            ti = 2'(n);
            put(1'b0, 1'b1);
            chk("select_live", 32'h3, 32'(fs)); // register select before expiry
            lim = 20 << n;
            for (k = 0; k < lim + 10 && tf !== 1'b1; k++) @(negedge clk);
            chk("interval", 32'h1, 32'(k >= lim - 3 && k <= lim + 3));
            for (k = 0; k < 40 && po !== 1'b0; k++) @(negedge clk);
            // select settles two edges after expiry, well inside the pulse
            for (k = 0; k < 40 && po === 1'b0; k++) begin
                if (k == 2) chk("select_zero", 32'h0, 32'(fs)); // back to config zero
                @(negedge clk);
            end
            chk("pulse_len", 32'd10, 32'(k)); // reset pulse length
            chk("pin1_drive", 32'h1, 32'(poe)); // pin acts as reset out
            tick(2);
            chk("switch_off", 32'h0, 32'(fs)); // switching off after reset
        end
        results();
    end
endmodule
`default_nettype wire
